// >>> core/scl_loader.sv
// Purpose: fetch prom words 06h/0Ch/0Eh and overlay them on per-port config words
// Assumes: word reader front end on mclk answers with ee_valid; data ok in the same cycle
// Notes:   config words outside the overlay read zero; overlay fields without a fetched word return the default parameters
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "scl_defines.svh"

module scl_loader #(
	parameter int          NPORT       = 3,
	parameter logic [15:0] TIMEOUT     = `SCL_EE_TIMEOUT,
	parameter logic [31:0] DEF_INTPIN  = 32'h0000_0000,
	parameter logic [31:0] DEF_CAPDIS  = 32'h0000_0000,
	parameter logic [31:0] DEF_SWMODE  = 32'h0000_0000,
	parameter logic [31:0] DEF_TLCTRL  = 32'h0000_0000,
	parameter logic [31:0] DEF_MARGIN  = 32'h0000_0000,
	parameter logic [31:0] DEF_DEVCAP  = 32'h0000_0000,
	parameter logic [31:0] DEF_LNKCAP  = 32'h0000_0000,
	parameter logic [31:0] DEF_DEVCAP2 = 32'h0000_0000,
	parameter logic [31:0] DEF_EXTVC   = 32'h0000_0000
) (
	input  wire logic        mclk,       // core clock
	input  wire logic        rst_n,      // synchronous reset
	output logic             ee_req,     // word read request pulse
	output logic [7:0]       ee_addr,    // prom word byte address
	input  wire logic        ee_valid,   // word answer strobe
	input  wire logic [15:0] ee_data,    // word answer data
	input  wire logic [11:0] reg_addr,   // port select and byte offset
	input  wire logic [31:0] reg_wdata,  // write data
	input  wire logic        reg_wr,     // write strobe
	input  wire logic        reg_rd,     // read strobe
	output logic [31:0]      reg_rdata,  // read data, cycle after strobe
	output logic             cfg_ready   // overrides in place
);

	scl_pkg::scl_state_t state_ff;
	scl_pkg::scl_state_t nxt_state;
	logic [1:0]          idx_ff;
	logic [15:0]         tmo_ff;
	logic [2:0]          vld_ff;
	logic                tmo_err_ff;
	logic                req_ff;
	logic [7:0]          addr_ff;
	logic [31:0]         rdata_ff;
	scl_pkg::scl_word_t  w06_ff [NPORT];
	scl_pkg::scl_word_t  w0c_ff [NPORT];
	scl_pkg::scl_word_t  w0e_ff [NPORT];

	logic reload;
	logic last_word;
	logic word_end;
	assign reload    = reg_wr && (reg_addr[11:10] == `SCL_SEL_LOADER) &&
	                   (reg_addr[9:0] == `SCL_LDR_CTRL) && reg_wdata[`SCL_CTRL_RELOAD];
	assign last_word = (idx_ff == 2'h2);
	assign word_end  = (state_ff == scl_pkg::ST_WAIT) && (ee_valid || (tmo_ff == TIMEOUT));

	function automatic logic [7:0] word_addr(input logic [1:0] i);
		logic [7:0] a;
		a = `SCL_EE_W06;
		unique case (i)
			2'h1:    a = `SCL_EE_W0C;
			2'h2:    a = `SCL_EE_W0E;
			default: a = `SCL_EE_W06;
		endcase
		return a;
	endfunction : word_addr

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			scl_pkg::ST_IDLE: nxt_state = scl_pkg::ST_REQ;
			scl_pkg::ST_REQ:  nxt_state = scl_pkg::ST_WAIT;
			scl_pkg::ST_WAIT: begin
				if (word_end)
					nxt_state = last_word ? scl_pkg::ST_DONE : scl_pkg::ST_REQ;
			end
			scl_pkg::ST_DONE: begin
				if (reload)
					nxt_state = scl_pkg::ST_IDLE;
			end
		endcase
	end

	// load starts straight after reset; a reload in ST_DONE restarts the sequence
	always_ff @(posedge mclk) begin
		if (!rst_n)
			state_ff <= scl_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || state_ff == scl_pkg::ST_IDLE)
			idx_ff <= 2'h0;
		else if (word_end && !last_word)
			idx_ff <= idx_ff + 2'h1;
	end

	// a silent prom must not hang the switch: give up on the word, keep defaults
	always_ff @(posedge mclk) begin
		if (!rst_n || state_ff != scl_pkg::ST_WAIT || ee_valid)
			tmo_ff <= 16'h0000;
		else if (tmo_ff != TIMEOUT)
			tmo_ff <= tmo_ff + 16'h0001;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			req_ff  <= 1'b0;
			addr_ff <= 8'h00;
		end else begin
			req_ff  <= (nxt_state == scl_pkg::ST_REQ);
			// idx_ff clears on the same edge as the idle request, so idle always asks word 0
			addr_ff <= (nxt_state != scl_pkg::ST_REQ) ? addr_ff
			         : (state_ff == scl_pkg::ST_WAIT) ? word_addr(idx_ff + 2'h1)
			         : word_addr(2'h0);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || state_ff == scl_pkg::ST_IDLE) begin
			vld_ff     <= 3'h0;
			tmo_err_ff <= 1'b0;
		end else if (word_end) begin
			if (ee_valid)
				vld_ff[idx_ff] <= 1'b1;
			else
				tmo_err_ff <= 1'b1;
		end
	end

	// every port keeps its own copy of each word
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				w06_ff[p] <= 16'h0000;
				w0c_ff[p] <= 16'h0000;
				w0e_ff[p] <= 16'h0000;
			end else if (state_ff == scl_pkg::ST_WAIT && ee_valid) begin
				unique case (idx_ff)
					2'h0:    w06_ff[p] <= ee_data;
					2'h1:    w0c_ff[p] <= ee_data;
					default: w0e_ff[p] <= ee_data;
				endcase
			end
		end
	end

	function automatic logic [31:0] cfg_word(input logic [1:0] port, input logic [9:0] off);
		logic [31:0] v;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic        up;
		v  = 32'h0000_0000;
		a  = w06_ff[port];
		b  = w0c_ff[port];
		c  = w0e_ff[port];
		up = (port != 2'h0);
		// only fields carried by a fetched word change; the rest stays default
		unique case (off)
			`SCL_CFG_EXTVC: begin
				v = DEF_EXTVC;
				if (vld_ff[0]) v[`SCL_EXTVC_CNT] = a[0];
			end
			`SCL_CFG_LNKCAP: begin
				v = DEF_LNKCAP;
				if (vld_ff[0]) begin
					v[`SCL_LC_L0S +: 3] = a[3:1];
					v[`SCL_LC_L1 +: 3]  = a[6:4];
				end
				if (vld_ff[1]) begin
					v[`SCL_LC_ASPM +: 2] = b[3:2];
					v[`SCL_LC_SDOWN]     = b[12];
					if (up) v[`SCL_LC_BWNOT] = b[9];
				end
			end
			`SCL_CFG_SWMODE: begin
				v = DEF_SWMODE;
				if (vld_ff[0]) begin
					v[`SCL_SW_NOEGR]    = a[8];
					v[`SCL_SW_NOTAG]    = a[9];
					v[`SCL_SW_SAF]      = a[10];
					v[`SCL_SW_CUT +: 2] = a[12:11];
					v[`SCL_SW_ARB]      = a[13];
					v[`SCL_SW_CRED]     = a[14];
				end
				if (vld_ff[1]) v[`SCL_SW_PARDIS] = b[6];
			end
			`SCL_CFG_INTPIN: begin
				v = DEF_INTPIN;
				if (vld_ff[0] && up) v[`SCL_IP_INTA] = a[15];
			end
			`SCL_CFG_DEVCAP: begin
				v = DEF_DEVCAP;
				if (vld_ff[1]) begin
					v[`SCL_DC_PAYLOAD +: 2] = b[1:0];
					v[`SCL_DC_RBER]         = b[4];
				end
			end
			`SCL_CFG_CAPDIS: begin
				v = DEF_CAPDIS;
				if (vld_ff[1]) begin
					v[`SCL_CD_MSIDIS] = b[5];
					v[`SCL_CD_PMDIS]  = b[7];
				end
			end
			`SCL_CFG_TLCTRL: begin
				v = DEF_TLCTRL;
				if (vld_ff[1]) begin
					v[`SCL_TL_PPNP]   = b[8];
					v[`SCL_TL_FREEZE] = b[10];
					v[`SCL_TL_SOFLAT] = b[11];
					v[`SCL_TL_DSELRW] = b[13];
					v[`SCL_TL_4KB]    = b[15];
				end
			end
			`SCL_CFG_DEVCAP2: begin
				v = DEF_DEVCAP2;
				if (vld_ff[1]) v[`SCL_DC2_LTR]  = b[14];
				if (vld_ff[2]) v[`SCL_DC2_OBFF] = c[15];
			end
			`SCL_CFG_MARGIN: begin
				v = DEF_MARGIN;
				if (vld_ff[2]) begin
					v[`SCL_MG_LOW +: 5]  = c[4:0];
					v[`SCL_MG_HIGH +: 5] = c[9:5];
					v[`SCL_MG_HALF +: 5] = c[14:10];
				end
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : cfg_word

	// read data live only in each cycle after a cycle with reg_rd high; unmapped offsets read zero
	always_ff @(posedge mclk) begin
		if (!rst_n || !reg_rd)
			rdata_ff <= 32'h0000_0000;
		else if (reg_addr[11:10] == `SCL_SEL_LOADER) begin
			rdata_ff <= 32'h0000_0000;
			if (reg_addr[9:0] == `SCL_LDR_CTRL) begin
				rdata_ff[`SCL_STAT_BUSY]     <= (state_ff != scl_pkg::ST_DONE);
				rdata_ff[`SCL_STAT_DONE]     <= (state_ff == scl_pkg::ST_DONE);
				rdata_ff[`SCL_STAT_TMO]      <= tmo_err_ff;
				rdata_ff[`SCL_STAT_VLD +: 3] <= vld_ff;
			end
		end else if (reg_addr[1:0] == 2'h0 && 32'(reg_addr[11:10]) < NPORT)
			rdata_ff <= cfg_word(reg_addr[11:10], reg_addr[9:0]);
		else
			rdata_ff <= 32'h0000_0000;
	end

	assign ee_req    = req_ff;
	assign ee_addr   = addr_ff;
	assign reg_rdata = rdata_ff;
	assign cfg_ready = (state_ff == scl_pkg::ST_DONE);

endmodule : scl_loader

// >>> include/scl_defines.svh
// Purpose: constants for the serial prom configuration word loader
// Assumes: 32-bit config words, byte offsets multiple of four
// Notes:   definitions only
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

`define SCL_EE_W06        8'h06
`define SCL_EE_W0C        8'h0c
`define SCL_EE_W0E        8'h0e
`define SCL_EE_TIMEOUT    16'h0400

`define SCL_CFG_INTPIN    10'h03c
`define SCL_CFG_CAPDIS    10'h070
`define SCL_CFG_SWMODE    10'h074
`define SCL_CFG_TLCTRL    10'h08c
`define SCL_CFG_MARGIN    10'h094
`define SCL_CFG_DEVCAP    10'h0c4
`define SCL_CFG_LNKCAP    10'h0cc
`define SCL_CFG_DEVCAP2   10'h0e4
`define SCL_CFG_EXTVC     10'h144

`define SCL_SEL_LOADER    2'h3
`define SCL_LDR_CTRL      10'h000
`define SCL_CTRL_RELOAD   0
`define SCL_STAT_BUSY     0
`define SCL_STAT_DONE     1
`define SCL_STAT_TMO      2
`define SCL_STAT_VLD      4

`define SCL_EXTVC_CNT     0
`define SCL_LC_ASPM       10
`define SCL_LC_L0S        12
`define SCL_LC_L1         15
`define SCL_LC_SDOWN      19
`define SCL_LC_BWNOT      21
`define SCL_SW_SAF        0
`define SCL_SW_CUT        1
`define SCL_SW_ARB        3
`define SCL_SW_CRED       4
`define SCL_SW_NOEGR      5
`define SCL_SW_NOTAG      6
`define SCL_SW_PARDIS     15
`define SCL_IP_INTA       8
`define SCL_DC_PAYLOAD    0
`define SCL_DC_RBER       15
`define SCL_CD_PMDIS      13
`define SCL_CD_MSIDIS     14
`define SCL_TL_SOFLAT     0
`define SCL_TL_DSELRW     1
`define SCL_TL_4KB        3
`define SCL_TL_PPNP       5
`define SCL_TL_FREEZE     6
`define SCL_MG_LOW        0
`define SCL_MG_HIGH       5
`define SCL_MG_HALF       10
`define SCL_DC2_LTR       12
`define SCL_DC2_OBFF      18

`endif

// >>> include/scl_pkg.sv
// Purpose: types of the serial prom configuration word loader
// Assumes: nothing
// Notes:   constants live in scl_defines.svh
package scl_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DONE} scl_state_t;
	typedef logic [15:0] scl_word_t;
endpackage : scl_pkg

// >>> testbench/scl_loader_assertions.sv
// Purpose: port-level checks of the prom word loader
// Assumes: one clock, synchronous reset
// Notes:   word order tracked in a small helper register
`timescale 1ns/1ns
module scl_loader_assertions (
	input wire logic        mclk,      // clock
	input wire logic        rst_n,     // reset
	input wire logic        ee_req,    // request
	input wire logic [7:0]  ee_addr,   // word address
	input wire logic        ee_valid,  // answer
	input wire logic [11:0] reg_addr,  // address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic        reg_wr,    // write
	input wire logic        reg_rd,    // read
	input wire logic [31:0] reg_rdata, // read data
	input wire logic        cfg_ready  // done
);
	logic [7:0] last_ff;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			last_ff <= 8'h0e;
		else if (ee_req)
			last_ff <= ee_addr;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_req_pulse: assert property (ee_req |=> !ee_req)
		else $error("request wider than one cycle");
	a_word_order: assert property (ee_req |-> (ee_addr == 8'h06 && last_ff == 8'h0e)
		|| (ee_addr == 8'h0c && last_ff == 8'h06) || (ee_addr == 8'h0e && last_ff == 8'h0c))
		else $error("word requested out of order");
	a_next_gap: assert property (ee_valid && ee_addr != 8'h0e |-> ##1 ee_req)
		else $error("next request not one cycle after answer");
	a_ready_after: assert property (ee_valid && ee_addr == 8'h0e |-> ##[1:2] cfg_ready)
		else $error("ready late after last word");
	a_ready_quiet: assert property (cfg_ready |-> !ee_req)
		else $error("request while ready");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_ready_hold: assert property (cfg_ready && !(reg_wr && reg_addr == 12'hc00) |=> cfg_ready)
		else $error("ready dropped without reload");
	a_reload_drop: assert property (reg_wr && reg_addr == 12'hc00 && reg_wdata[0] && cfg_ready
		|-> ##[1:2] !cfg_ready)
		else $error("reload did not restart");
	cover property (ee_valid && ee_addr == 8'h0e);
	cover property ($rose(cfg_ready));
	cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : scl_loader_assertions

bind scl_loader scl_loader_assertions chk_u (.mclk, .rst_n, .ee_req, .ee_addr, .ee_valid,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_ready);

// >>> testbench/scl_prom_model.sv
// Purpose: prom word source facing the loader
// Assumes: dly between 1 and 8, well inside the loader timeout
// Notes:   idle data toggles so a stale word never looks valid
`timescale 1ns/1ns
module scl_prom_model (
	input  wire logic        mclk,     // clock
	input  wire logic        ee_req,   // request
	input  wire logic [7:0]  ee_addr,  // word address
	input  wire logic [15:0] w06,      // word 06h
	input  wire logic [15:0] w0c,      // word 0Ch
	input  wire logic [15:0] w0e,      // word 0Eh
	input  wire logic [3:0]  dly,      // answer delay
	input  wire logic        mute,     // never answer
	output logic             ee_valid, // answer strobe
	output logic [15:0]      ee_data   // answer word
);
	logic [3:0] cnt_ff = 4'h0;

	initial ee_valid = 1'b0;
	initial ee_data = 16'h0000;
	always @(posedge mclk) begin
		if (ee_req && !mute)
			cnt_ff <= dly;
		else if (cnt_ff != 4'h0)
			cnt_ff <= cnt_ff - 4'h1;
		ee_valid <= (cnt_ff == 4'h1);
		ee_data  <= (cnt_ff != 4'h1) ? ~ee_data :
		            (ee_addr == 8'h06) ? w06 : (ee_addr == 8'h0c) ? w0c : w0e;
	end
endmodule : scl_prom_model

// >>> testbench/tb_serial_prom_config_word_loader.sv
// Purpose: self-checking bench of the prom word loader
// Assumes: default config values all zero, short timeout
// Notes:   random words plus all-ones, all-zeros and silent prom
`timescale 1ns/1ns
module tb_serial_prom_config_word_loader;
	logic        mclk, rst_n, reg_wr, reg_rd, mute, ee_req, ee_valid, cfg_ready;
	logic [7:0]  ee_addr;
	logic [15:0] ee_data, w06, w0c, w0e;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [3:0]  dly;
	int          err_total, n_checks;
	// last two are misaligned and unmapped places
	localparam logic [9:0] OFFS [11] = '{10'h03c, 10'h070, 10'h074, 10'h08c, 10'h094,
		10'h0c4, 10'h0cc, 10'h0e4, 10'h144, 10'h0ce, 10'h3f0};

	scl_loader #(.TIMEOUT(16'h0010)) dut_u (.mclk(mclk), .rst_n(rst_n), .ee_req(ee_req),
		.ee_addr(ee_addr), .ee_valid(ee_valid), .ee_data(ee_data), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cfg_ready(cfg_ready));
	scl_prom_model prom_u (.mclk(mclk), .ee_req(ee_req), .ee_addr(ee_addr), .w06(w06),
		.w0c(w0c), .w0e(w0e), .dly(dly), .mute(mute), .ee_valid(ee_valid), .ee_data(ee_data));

	always #5 mclk = ~mclk;

	function automatic logic [31:0] exp_cfg(int p, logic [9:0] o, logic [15:0] a, b, c);
		logic [31:0] e;
		e = 32'h0;
		case (o)
			10'h144: e[0] = a[0];
			10'h03c: e[8] = (p != 0) & a[15];
			10'h074: e[15:0] = {b[6], 8'h0, a[9:8], a[14:13], a[12:11], a[10]};
			10'h0cc: e = {10'h0, (p != 0) & b[9], 1'b0, b[12], 1'b0, a[6:1], b[3:2], 10'h0};
			10'h0c4: e = {16'h0, b[4], 13'h0, b[1:0]};
			10'h070: e = {17'h0, b[5], b[7], 13'h0};
			10'h08c: e = {25'h0, b[10], b[8], 1'b0, b[15], 1'b0, b[13], b[11]};
			10'h094: e[14:0] = c[14:0];
			10'h0e4: e = {13'h0, c[15], 5'h0, b[14], 12'h0};
			default: e = 32'h0;
		endcase
		return e;
	endfunction : exp_cfg

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic wait_ready();
		// look past the edge so the flag read is the settled one
		for (int i = 0; i < 300 && cfg_ready !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
	endtask : wait_ready

	task automatic load(input logic [15:0] a, b, c, input logic m);
		w06  <= a;
		w0c  <= b;
		w0e  <= c;
		mute <= m;
		dly  <= 4'($urandom_range(8, 1));
		wr(12'hc00, 32'h1);
		repeat (3) @(posedge mclk);
		wait_ready();
	endtask : load

	// a silent prom must leave every field at its default
	task automatic check_all(input logic m);
		logic [15:0] a, b, c;
		a = m ? 16'h0 : w06;
		b = m ? 16'h0 : w0c;
		c = m ? 16'h0 : w0e;
		chk(32'(cfg_ready), 32'h1);
		wr(12'h4cc, 32'hffff_ffff);
		rd(12'hc00, d);
		chk(d, m ? 32'h6 : 32'h72);
		for (int p = 0; p < 3; p++)
			for (int k = 0; k < 11; k++) begin
				rd({2'(p), OFFS[k]}, d);
				chk(d, exp_cfg(p, OFFS[k], a, b, c));
			end
	endtask : check_all

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		summarize();
	end

	initial begin
		{mclk, rst_n, reg_wr, reg_rd, mute, reg_addr, reg_wdata} = '0;
		{w06, w0c, w0e, dly} = {16'ha5c3, 16'h5a3c, 16'hffff, 4'h3};
		err_total = 0;
		n_checks = 0;
		d = $urandom(78218);
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		wait_ready();
		check_all(1'b0);
		load(16'hffff, 16'hffff, 16'h0000, 1'b0);
		check_all(1'b0);
		load(16'h0000, 16'h0000, 16'hffff, 1'b0);
		check_all(1'b0);
		load(16'hffff, 16'hffff, 16'hffff, 1'b1);
		check_all(1'b1);
		for (int i = 0; i < 6; i++) begin
			load(16'($urandom), 16'($urandom), 16'($urandom), 1'b0);
			check_all(1'b0);
		end
		summarize();
	end
endmodule : tb_serial_prom_config_word_loader
